/* File: fsq_flash_seq.v */
// flash command sequencer: erase, suspend/resume, status flags, ecc word writes
// assumes an apb master and a flash array macro with combinational read data
//
// Contract
// - full chip erase sequence starts algorithm erasing every sector at once
// - during chip erase any read returns flags; bit 7 one means done
// - finished erase returns to read mode without a further command
// - sector erase waits 35 us timeout before erasing starts
// - code 0x30 within timeout adds a sector; later codes are rejected
// - during sector erase any read returns flags; bit 7 one means done
// - toggle flag alternates between reads while sector erase runs
// - polarity flag changes in the same cycle as timing limit flag; here bit 7 keeps its value when bit 5 sets
// - toggle stops alternating when timing limit flag becomes one
// - during sector erase only sector codes and suspend are accepted; here sector codes only in the timeout, erasing takes suspend alone
// - suspend at any address in timeout or erase enters suspended state
// - suspend halts timeout at once and stops erase within 35 us
// - chip erase cannot be suspended; suspend while suspended is ignored
// - resume returns to erasing, never to the timeout state
// - while suspended selected sectors read flags, others read array data
// - new write or erase sequences are ignored while suspended
// - resume accepted only while suspended, at any address
// - erasing resumes over 2 ms after resume; suspend early may trip limit
// - low half at word address then high half at +2; ecc on second
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "fsq_regs.vh"

module fsq_flash_seq #(
    parameter [23:0] SE_ERASE_CYC = 24'h004E20,
    parameter [23:0] CHIP_ERASE_CYC = 24'h009C40,
    parameter [23:0] PROG_CYC = 24'h000064,
    parameter [23:0] LIMIT_CYC = 24'h07A120,
    parameter [23:0] RESUME_CYC = `FSQ_RESUME_CYC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // flash array macro
    output reg [15:0] arr_addr,
    input wire [31:0] arr_rdata,
    input wire arr_ecc_corr,
    output reg arr_wr,
    output reg [31:0] arr_wdata,
    output reg [6:0] arr_wecc,
    output reg arr_erase,
    output reg [7:0] arr_erase_mask,
    // status
    output wire busy
);

    // sequencer states; the codes show in status bits 4:2
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_PROG = 3'h1;
    localparam [2:0] ST_CHIP = 3'h2;
    localparam [2:0] ST_SE_TO = 3'h3;
    localparam [2:0] ST_SE_ER = 3'h4;
    localparam [2:0] ST_SUSP = 3'h5;
    localparam [2:0] ST_RESUME = 3'h6;
    // fixed 35 us window, never shortened for simulation
    localparam [23:0] SE_TO_CYC = `FSQ_SE_TIMEOUT_CYC;

    // sequencer core
    reg [2:0] state_reg;
    reg [2:0] cyc_reg;

    // program half-word pairing
    reg prog_arm_reg;
    reg hi_pend_reg;
    reg [15:0] lo_half_reg;
    reg [13:0] lo_addr_reg;
    reg pol_bit_reg;

    // step, erase and rated time counters
    reg [23:0] tmr_reg;
    reg [23:0] er_cnt_reg;
    reg [23:0] lim_reg;

    // flag sources
    reg tlim_reg;
    reg tog_reg;
    reg tog2_reg;
    reg [7:0] sel_reg;

    // software visible bits
    reg [1:0] asz_reg;
    reg err_reg;

    // bus answer
    reg ack_reg;
    reg slverr_reg;

    // seven parity bits, one per mask
    // a single flipped bit shows as a nonzero syndrome on read
    function [6:0] fsq_ecc;
        input [31:0] d;
        begin
            fsq_ecc[0] = ^(d & `FSQ_ECC_M0);
            fsq_ecc[1] = ^(d & `FSQ_ECC_M1);
            fsq_ecc[2] = ^(d & `FSQ_ECC_M2);
            fsq_ecc[3] = ^(d & `FSQ_ECC_M3);
            fsq_ecc[4] = ^(d & `FSQ_ECC_M4);
            fsq_ecc[5] = ^(d & `FSQ_ECC_M5);
            fsq_ecc[6] = ^(d & `FSQ_ECC_M6);
        end
    endfunction

    // bus decode: bit 15 picks registers over the flash window
    wire is_reg = paddr[`FSQ_REG_SPACE_BIT];
    wire acc_first = psel & penable & ~ack_reg;
    wire acc_done = psel & penable & ack_reg;
    // command byte from the addressed half-word
    wire [15:0] wr_half = paddr[1] ? pwdata[31:16] : pwdata[15:0];
    wire [7:0] cmd = wr_half[7:0];
    wire [2:0] sect = paddr[14:12];
    // flash writes count only in 16-bit programming mode
    wire prog_mode = (asz_reg == `FSQ_ASZ_PROG);
    wire fwr = acc_done & pwrite & ~is_reg & prog_mode;
    wire frd = acc_done & ~pwrite & ~is_reg;
    wire reg_ok = (paddr == `FSQ_ACCESS_SIZE_OFS) | (paddr == `FSQ_STATUS_OFS);

    // flags replace array data whenever the algorithm owns the array
    wire flag_sel = (state_reg == ST_SUSP) ? sel_reg[sect] :
        (state_reg != ST_IDLE);
    // 7 polarity, 6 toggle, 5 limit, 3 past window, 2 toggle2
    wire [7:0] flags_busy = {
        (state_reg == ST_PROG) ? pol_bit_reg : 1'b0,
        tlim_reg | tog_reg,
        tlim_reg,
        1'b0,
        (state_reg != ST_SE_TO),
        (state_reg == ST_PROG) ? 1'b0 : tog2_reg,
        2'h0};
    // suspended: bit 6 and 5 read zero, bit 3 one, bit 2 still toggles
    wire [7:0] flags_susp = {4'h0, 1'b1, tog2_reg, 2'h0};
    wire [7:0] flags = (state_reg == ST_SUSP) ? flags_susp : flags_busy;
    // status: bit 0 ecc error, bit 1 busy, bits 4:2 state
    wire [31:0] status_word = {27'h0, state_reg, busy, err_reg};

    // handshake and busy are combinational, data outputs are flops
    assign busy = (state_reg != ST_IDLE);
    assign pready = psel & penable & ack_reg;
    assign pslverr = pready & slverr_reg;

    // apb pacing: one wait cycle so read data comes from a flop
    // setup edge latches the array address, first access edge loads prdata,
    // second access edge ends the transfer and a write acts there
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
            slverr_reg <= 1'b0;
            arr_addr <= 16'h0000;
            prdata <= 32'h00000000;
        end else begin
            ack_reg <= acc_first;
            if (psel & ~penable) begin
                arr_addr <= paddr;
            end
            if (acc_first) begin
                // flash writes outside programming mode are refused
                slverr_reg <= is_reg ? ~reg_ok : (pwrite & ~prog_mode);
                if (is_reg) begin
                    prdata <= (paddr == `FSQ_ACCESS_SIZE_OFS) ? {30'h0, asz_reg} :
                        (paddr == `FSQ_STATUS_OFS) ? status_word : 32'h00000000;
                end else if (flag_sel) begin
                    prdata <= {24'h0, flags};
                end else begin
                    prdata <= arr_rdata;
                end
            end
        end
    end

    // software registers; error flag set wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asz_reg <= `FSQ_ASZ_RESET;
            err_reg <= 1'b0;
        end else begin
            if (acc_done & pwrite & (paddr == `FSQ_ACCESS_SIZE_OFS) & pstrb[0]) begin
                asz_reg <= pwdata[1:0];
            end
            if (arr_ecc_corr) begin
                err_reg <= 1'b1;
            end else if (acc_done & pwrite & (paddr == `FSQ_STATUS_OFS) & pstrb[0] &
                    pwdata[`FSQ_ST_ERR_BIT]) begin
                err_reg <= 1'b0;
            end
        end
    end

    // toggle flags flip on every completed flag read while running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_reg <= 1'b0;
            tog2_reg <= 1'b0;
        end else if (frd & flag_sel) begin
            if (!tlim_reg && state_reg != ST_SUSP) begin
                tog_reg <= ~tog_reg;
            end
            if (!tlim_reg) begin
                tog2_reg <= ~tog2_reg;
            end
        end
    end

    // command sequencer; low byte of the half-word, address not checked
    // program AA 55 A0 data; chip AA 55 80 AA 55 10; sector ends in 30
    // sector erase takes its sector from the address of the last code
    // F0 drops a partial sequence, except after A0 where it is program data, and also clears a limit hang
    // timeout hears only 30 and B0, erasing only B0; suspended hears only 30 (resume)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cyc_reg <= 3'h0;
            prog_arm_reg <= 1'b0;
            hi_pend_reg <= 1'b0;
            lo_half_reg <= 16'h0000;
            lo_addr_reg <= 14'h0000;
            pol_bit_reg <= 1'b0;
            tmr_reg <= 24'h000000;
            er_cnt_reg <= 24'h000000;
            lim_reg <= 24'h000000;
            tlim_reg <= 1'b0;
            sel_reg <= 8'h00;
            arr_wr <= 1'b0;
            arr_wdata <= 32'h00000000;
            arr_wecc <= 7'h00;
            arr_erase <= 1'b0;
            arr_erase_mask <= 8'h00;
        end else begin
            arr_wr <= 1'b0;
            arr_erase <= 1'b0;
            // rated time watchdog over a whole operation, suspend excluded
            if (busy && state_reg != ST_SUSP && !tlim_reg) begin
                lim_reg <= lim_reg + 24'h000001;
                if (lim_reg == LIMIT_CYC) begin
                    tlim_reg <= 1'b1;
                end
            end
            if (tlim_reg) begin
                // algorithm hangs until the reset command
                if (fwr && cmd == `FSQ_CMD_RESET) begin
                    tlim_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                    cyc_reg <= 3'h0;
                    lim_reg <= 24'h000000;
                end
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        tmr_reg <= 24'h000000;
                        lim_reg <= 24'h000000;
                        if (fwr && prog_arm_reg) begin
                            prog_arm_reg <= 1'b0;
                            pol_bit_reg <= ~wr_half[7];
                            state_reg <= ST_PROG;
                            if (!paddr[1]) begin
                                lo_half_reg <= wr_half;
                                lo_addr_reg <= paddr[15:2];
                                hi_pend_reg <= 1'b1;
                            end else if (hi_pend_reg && paddr[15:2] == lo_addr_reg) begin
                                hi_pend_reg <= 1'b0;
                                arr_wr <= 1'b1;
                                arr_wdata <= {wr_half, lo_half_reg};
                                arr_wecc <= fsq_ecc({wr_half, lo_half_reg});
                            end
                        end else if (fwr) begin
                            if (cmd == `FSQ_CMD_RESET) begin
                                cyc_reg <= 3'h0;
                            end else begin
                                case (cyc_reg)
                                    3'h0, 3'h3: cyc_reg <= (cmd == `FSQ_CMD_UNLOCK1) ?
                                        cyc_reg + 3'h1 : 3'h0;
                                    3'h1, 3'h4: cyc_reg <= (cmd == `FSQ_CMD_UNLOCK2) ?
                                        cyc_reg + 3'h1 : 3'h0;
                                    3'h2: begin
                                        cyc_reg <= (cmd == `FSQ_CMD_ERASE) ? 3'h3 : 3'h0;
                                        prog_arm_reg <= (cmd == `FSQ_CMD_PROGRAM);
                                    end
                                    3'h5: begin
                                        cyc_reg <= 3'h0;
                                        if (cmd == `FSQ_CMD_CHIP) begin
                                            sel_reg <= 8'hFF;
                                            state_reg <= ST_CHIP;
                                        end else if (cmd == `FSQ_CMD_SECTOR) begin
                                            sel_reg <= 8'h01 << sect;
                                            er_cnt_reg <= 24'h000000;
                                            state_reg <= ST_SE_TO;
                                        end
                                    end
                                    default: cyc_reg <= 3'h0;
                                endcase
                            end
                        end
                    end
                    ST_PROG: begin
                        // every command is ignored until the write ends
                        tmr_reg <= tmr_reg + 24'h000001;
                        if (tmr_reg == PROG_CYC) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_CHIP: begin
                        // no suspend path exists from here
                        tmr_reg <= tmr_reg + 24'h000001;
                        if (tmr_reg == CHIP_ERASE_CYC) begin
                            arr_erase <= 1'b1;
                            arr_erase_mask <= sel_reg;
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SE_TO: begin
                        // window counts up; each new sector restarts it
                        tmr_reg <= tmr_reg + 24'h000001;
                        if (fwr && cmd == `FSQ_CMD_SUSPEND) begin
                            state_reg <= ST_SUSP;
                        end else if (fwr && cmd == `FSQ_CMD_SECTOR) begin
                            // each added sector restarts the window
                            sel_reg <= sel_reg | (8'h01 << sect);
                            tmr_reg <= 24'h000000;
                        end else if (tmr_reg == SE_TO_CYC) begin
                            state_reg <= ST_SE_ER;
                        end
                    end
                    // limitation: erase time ignores the number of sectors
                    ST_SE_ER: begin
                        // late sector codes fall through unheeded
                        er_cnt_reg <= er_cnt_reg + 24'h000001;
                        if (fwr && cmd == `FSQ_CMD_SUSPEND) begin
                            // stops at once, well inside the allowed delay
                            state_reg <= ST_SUSP;
                        end else if (er_cnt_reg == SE_ERASE_CYC) begin
                            arr_erase <= 1'b1;
                            arr_erase_mask <= sel_reg;
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SUSP: begin
                        // only the resume code is heeded; repeat suspend ignored
                        tmr_reg <= 24'h000000;
                        if (fwr && cmd == `FSQ_CMD_SECTOR) begin
                            state_reg <= ST_RESUME;
                        end
                    end
                    ST_RESUME: begin
                        // restart delay counts toward the rated time
                        tmr_reg <= tmr_reg + 24'h000001;
                        if (fwr && cmd == `FSQ_CMD_SUSPEND) begin
                            state_reg <= ST_SUSP;
                        end else if (tmr_reg == RESUME_CYC) begin
                            state_reg <= ST_SE_ER;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

/* File: fsq_regs.vh */
// constants for the flash erase / ecc write sequencer
// assumes a 100 MHz apb clock; the timeout and resume counts derive from the times below
`ifndef FSQ_REGS_VH
`define FSQ_REGS_VH

// register offsets (byte addresses, flash window below 0x8000)
`define FSQ_ACCESS_SIZE_OFS 16'h8000
`define FSQ_STATUS_OFS 16'h8004
`define FSQ_REG_SPACE_BIT 15

// access size field values
`define FSQ_ASZ_PROG 2'h1
`define FSQ_ASZ_ROM 2'h2
`define FSQ_ASZ_RESET 2'h2

// status register fields
`define FSQ_ST_ERR_BIT 0
`define FSQ_ST_BUSY_BIT 1
`define FSQ_ST_STATE_LSB 2

// hardware sequence flag positions
`define FSQ_FLAG_POL 7
`define FSQ_FLAG_TOG 6
`define FSQ_FLAG_TLIM 5
`define FSQ_FLAG_SETI 3
`define FSQ_FLAG_TOG2 2

// command codes
`define FSQ_CMD_UNLOCK1 8'hAA
`define FSQ_CMD_UNLOCK2 8'h55
`define FSQ_CMD_PROGRAM 8'hA0
`define FSQ_CMD_ERASE 8'h80
`define FSQ_CMD_CHIP 8'h10
`define FSQ_CMD_SECTOR 8'h30
`define FSQ_CMD_SUSPEND 8'hB0
`define FSQ_CMD_RESET 8'hF0

// timing; 24-bit operands so the counts fit the 24-bit timers exactly
`define FSQ_CLK_NS 24'h00000A
`define FSQ_SE_TIMEOUT_NS 24'h0088B8
`define FSQ_RESUME_NS 24'h1E8480
`define FSQ_SE_TIMEOUT_CYC ((`FSQ_SE_TIMEOUT_NS + `FSQ_CLK_NS - 24'h000001) / `FSQ_CLK_NS)
`define FSQ_RESUME_CYC (`FSQ_RESUME_NS / `FSQ_CLK_NS + 24'h000001)

// ecc parity masks over a 32-bit word
`define FSQ_ECC_M0 32'h56AAAD5B
`define FSQ_ECC_M1 32'h9B33366D
`define FSQ_ECC_M2 32'hE3C3C78E
`define FSQ_ECC_M3 32'h03FC07F0
`define FSQ_ECC_M4 32'h03FFF800
`define FSQ_ECC_M5 32'hFC000000
`define FSQ_ECC_M6 32'hFFFFFFFF

`endif

/* File: fsq_array_model.sv */
// behavioural flash array that stands behind the sequencer
// assumes byte addresses, 4 KB sectors, read data combinational from the address
`timescale 1ns/1ps
module fsq_array_model (
    // clock
    input wire pclk,
    // array port
    input wire [15:0] arr_addr,
    output wire [31:0] arr_rdata,
    input wire arr_wr,
    input wire [31:0] arr_wdata,
    input wire arr_erase,
    input wire [7:0] arr_erase_mask
);
    logic [31:0] mem [0:8191];
    integer i;
    // bit 7 set in the fill, so a finished program poll reads one
    initial begin
        for (i = 0; i < 8192; i++) mem[i] = 32'h5A5A5AA5;
    end
    assign arr_rdata = mem[arr_addr[14:2]];
    // whole word lands only on the high half write
    always @(posedge pclk) begin
        if (arr_wr === 1'b1) mem[arr_addr[14:2]] <= arr_wdata;
        if (arr_erase === 1'b1) begin
            for (i = 0; i < 8192; i++) begin
                if (arr_erase_mask[i[12:10]]) mem[i] <= 32'hFFFFFFFF;
            end
        end
    end
endmodule

/* File: fsq_flash_seq_checker.sv */
// timing and relation checks on the sequencer's ports
// assumes bind onto fsq_flash_seq and a master that holds each request until pready
`timescale 1ns/1ps
`include "fsq_regs.vh"
module fsq_flash_seq_checker (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // array and status
    input wire arr_wr,
    input wire [31:0] arr_wdata,
    input wire [6:0] arr_wecc,
    input wire arr_erase,
    input wire busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // the two phases of one transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // exactly one wait state
    property p_wait;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("pready not in second access cycle");
    property p_ready_in_access;
        pready |-> s_access;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    property p_prdata_holds;
        !psel |=> $stable(prdata);
    endproperty
    a_prdata_holds: assert property (p_prdata_holds) else $error("prdata moved while idle");
    property p_wr_pulse;
        arr_wr |=> !arr_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("array write longer than a cycle");
    // ecc bits follow the parity masks over the full word
    property p_ecc;
        arr_wr |-> arr_wecc == {^(arr_wdata & `FSQ_ECC_M6), ^(arr_wdata & `FSQ_ECC_M5),
            ^(arr_wdata & `FSQ_ECC_M4), ^(arr_wdata & `FSQ_ECC_M3), ^(arr_wdata & `FSQ_ECC_M2),
            ^(arr_wdata & `FSQ_ECC_M1), ^(arr_wdata & `FSQ_ECC_M0)};
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc bits wrong for word");
    property p_erase_done;
        arr_erase |-> ##[0:1] !busy;
    endproperty
    a_erase_done: assert property (p_erase_done) else $error("not idle after erase");
    property p_busy_cause;
        $rose(busy) |-> $past(psel && penable && pwrite && pready);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
endmodule
bind fsq_flash_seq fsq_flash_seq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_wecc(arr_wecc), .arr_erase(arr_erase),
    .busy(busy));

/* File: flash_erase_suspend_ecc_write_seq_test.sv */
// self-checking bench: register rows, erase, suspend, limit and ecc write cases
// assumes fsq_flash_seq with shortened counts and fsq_array_model behind it
`timescale 1ns/1ps
module flash_erase_suspend_ecc_write_seq_test;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] e; logic r;} fsq_row_t;
    logic pclk, presetn, psel, penable, pwrite, arr_ecc_corr, er;
    logic [15:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] pstrb;
    logic [7:0] lmask;
    wire pready, pslverr, arr_wr, arr_erase, busy;
    wire [31:0] prdata, arr_rdata, arr_wdata;
    wire [15:0] arr_addr;
    wire [6:0] arr_wecc;
    wire [7:0] arr_erase_mask;
    int error_cnt = 0, n_compared = 0, nwr = 0, k;
    time t0;
    fsq_row_t rows[8];
    fsq_flash_seq #(.SE_ERASE_CYC(24'h0000C8), .CHIP_ERASE_CYC(24'h000050),
        .PROG_CYC(24'h000005), .LIMIT_CYC(24'h000FA0), .RESUME_CYC(24'h000014)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .arr_addr(arr_addr), .arr_rdata(arr_rdata), .arr_ecc_corr(arr_ecc_corr),
        .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_wecc(arr_wecc), .arr_erase(arr_erase),
        .arr_erase_mask(arr_erase_mask), .busy(busy));
    fsq_array_model u_arr (.pclk(pclk), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
        .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_erase(arr_erase),
        .arr_erase_mask(arr_erase_mask));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // remember array writes and the last erase mask
    always @(posedge pclk) begin
        if (arr_wr === 1'b1) nwr <= nwr + 1;
        if (arr_erase === 1'b1) lmask <= arr_erase_mask;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; waits for pready, no fixed latency assumed
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int j;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge pclk);
            j++;
        end while (pready !== 1'b1 && j < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmd(input logic [15:0] a, input logic [7:0] c);
        apb(1'b1, a, {24'h000000, c});
    endtask
    task er6(input logic [15:0] a, input logic [7:0] c);
        logic [7:0] q[6];
        q = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, c};
        foreach (q[i]) cmd(a, q[i]);
    endtask
    // poll the state field, bounded
    task wst(input logic [2:0] s);
        int j;
        j = 0;
        do begin
            apb(1'b0, 16'h8004, 32'h0);
            j++;
        end while (rd[4:2] !== s && j < 2000);
        chk("state", {29'h0, s}, {29'h0, rd[4:2]});
    endtask
    // poll flags at an address until bit 7 reads one
    task pollf(input logic [15:0] a);
        int j;
        j = 0;
        do begin
            apb(1'b0, a, 32'h0);
            j++;
        end while (rd[7] !== 1'b1 && j < 500);
        chk("flag done", 32'h1, {31'h0, rd[7]});
    endtask
    task prog(input logic [15:0] a, input logic [31:0] d);
        cmd(16'h0000, 8'hAA);
        cmd(16'h0000, 8'h55);
        cmd(16'h0000, 8'hA0);
        apb(1'b1, a, d);
        apb(1'b0, a, 32'h0);
        pollf(a);
    endtask
    task tally_and_finish;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // cuts a hang short, far above the expected run length
    initial begin
        #600us;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        {presetn, psel, penable, pwrite, arr_ecc_corr} = 5'h00;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        rows = '{'{1'b0, 16'h8000, 32'h0, 32'h2, 1'b0}, '{1'b0, 16'h8004, 32'h0, 32'h0, 1'b0},
            '{1'b1, 16'h0000, 32'hAA, 32'h0, 1'b1}, '{1'b1, 16'h8000, 32'h1, 32'h0, 1'b0},
            '{1'b0, 16'h8000, 32'h0, 32'h1, 1'b0}, '{1'b0, 16'h8010, 32'h0, 32'h0, 1'b1},
            '{1'b1, 16'h8010, 32'h5, 32'h0, 1'b1}, '{1'b0, 16'h0004, 32'h0, 32'h5A5A5AA5, 1'b0}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("rdata", rows[i].e, rd);
            chk("slverr", {31'h0, rows[i].r}, {31'h0, er});
        end
        // chip erase, suspend refused
        er6(16'h0000, 8'h10);
        apb(1'b0, 16'h1000, 32'h0);
        chk("chip pol", 32'h0, {31'h0, rd[7]});
        cmd(16'h0000, 8'hB0);
        wst(3'h2);
        pollf(16'h1000);
        chk("chip mask", 32'hFF, {24'h0, lmask});
        wst(3'h0);
        // sector erase: timeout length, toggle, ignored commands
        er6(16'h5000, 8'h30);
        t0 = $time;
        apb(1'b0, 16'h5000, 32'h0);
        chk("timer flag", 32'h0, {31'h0, rd[3]});
        wst(3'h4);
        k = ($time - t0) / 10;
        chk("timeout", 32'h1, {31'h0, k >= 3498 && k <= 3512});
        apb(1'b0, 16'h5000, 32'h0);
        k = rd[6];
        apb(1'b0, 16'h5000, 32'h0);
        chk("toggle", {31'h0, ~k[0]}, {31'h0, rd[6]});
        cmd(16'h5000, 8'hF0);
        cmd(16'h0000, 8'h30);
        wst(3'h4);
        cmd(16'h0000, 8'hB0);
        wst(3'h5);
        cmd(16'h0000, 8'h30);
        wst(3'h4);
        pollf(16'h5000);
        chk("sector mask", 32'h20, {24'h0, lmask});
        wst(3'h0);
        // two sectors, suspend in the timeout, resume
        er6(16'h1000, 8'h30);
        cmd(16'h3000, 8'h30);
        cmd(16'h7000, 8'hB0);
        wst(3'h5);
        apb(1'b0, 16'h1000, 32'h0);
        chk("susp flags", 32'h01, {27'h0, rd[7:3]});
        apb(1'b0, 16'h2000, 32'h0);
        chk("susp data", 32'hFFFFFFFF, rd);
        cmd(16'h0000, 8'hB0);
        prog(16'h2000, 32'h0);
        wst(3'h5);
        cmd(16'h6000, 8'h30);
        wst(3'h6);
        wst(3'h4);
        pollf(16'h1000);
        chk("two mask", 32'h0A, {24'h0, lmask});
        // rapid resume and suspend trips the timing limit
        er6(16'h6000, 8'h30);
        cmd(16'h0000, 8'hB0);
        k = 0;
        rd = 32'h0;
        while (rd[5] !== 1'b1 && k < 1000) begin
            cmd(16'h0000, 8'h30);
            apb(1'b0, 16'h6000, 32'h0);
            if (rd[5] !== 1'b1) cmd(16'h0000, 8'hB0);
            k++;
        end
        chk("limit flags", 32'h3, {29'h0, rd[7:5]});
        apb(1'b0, 16'h6000, 32'h0);
        chk("limit toggle", 32'h3, {30'h0, rd[6:5]});
        cmd(16'h0000, 8'hF0);
        wst(3'h0);
        // ecc word write in two halves
        nwr = 0;
        prog(16'h2010, 32'h0000BEEF);
        prog(16'h2012, 32'hCAFE0000);
        chk("array writes", 32'h1, nwr);
        apb(1'b1, 16'h8000, 32'h2);
        apb(1'b0, 16'h8000, 32'h0);
        apb(1'b0, 16'h2010, 32'h0);
        chk("word", 32'hCAFEBEEF, rd);
        @(posedge pclk);
        arr_ecc_corr <= 1'b1;
        @(posedge pclk);
        arr_ecc_corr <= 1'b0;
        apb(1'b0, 16'h8004, 32'h0);
        chk("ecc err", 32'h1, {31'h0, rd[0]});
        apb(1'b1, 16'h8004, 32'h1);
        apb(1'b0, 16'h8004, 32'h0);
        chk("ecc clear", 32'h0, {31'h0, rd[0]});
        tally_and_finish;
    end
endmodule
